/* File: sbi_pkg.sv */
package sbi_pkg;
  // Clock and time base
  localparam int CLK_HZ       = 200_000_000;
  localparam int MS_PER_S     = 1000;
  localparam int S_PER_MIN    = 60;
  localparam int CYC_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int MS_W         = 20;
  localparam int CMD_WAIT_MIN = 10;
  localparam int CMD_WAIT_MS  = CMD_WAIT_MIN * S_PER_MIN * MS_PER_S;
  localparam int CRC_REQ_S    = 30;
  localparam int CRC_REQ_MS   = CRC_REQ_S * MS_PER_S;
  localparam int ABORT_S      = 20;
  localparam int ABORT_MS     = ABORT_S * MS_PER_S;
  localparam int C_REPEAT_MS  = 1000;
  localparam int PKT_GAP_MS   = 1000;

  // Session settings
  localparam logic [4:0] BAUD_BOOT   = 5'h05;
  localparam logic [4:0] BAUD_MIN8   = 5'h02;
  localparam logic [4:0] BAUD_MAX8   = 5'h09;
  localparam int         STATION_MAX = 99;
  localparam int         DUPLEX_MAX  = 1;
  localparam logic [7:0] BOOT_VER    = 8'h33;

  // Characters and commands
  localparam logic [7:0]  CH_0    = 8'h30;
  localparam logic [7:0]  CH_9    = 8'h39;
  localparam logic [7:0]  CH_A    = 8'h41;
  localparam logic [7:0]  CH_Z    = 8'h5A;
  localparam logic [7:0]  CH_C    = 8'h43;
  localparam logic [7:0]  CH_CR   = 8'h0D;
  localparam logic [15:0] CMD_UP  = 16'h5550;
  localparam logic [15:0] CMD_BAUD    = 16'h4252;
  localparam logic [15:0] CMD_STATION = 16'h4944;
  localparam logic [15:0] CMD_DUPLEX  = 16'h444D;
  localparam logic [15:0] UP_CANCEL = 16'h0000;
  localparam logic [15:0] UP_PARAM  = 16'h0001;
  localparam logic [15:0] UP_START  = 16'h0002;
  localparam logic [2:0]  PP_LETTER0 = 3'h2;
  localparam logic [2:0]  PP_VALUE   = 3'h4;

  // Image transfer framing
  localparam int          XM_PAYLOAD = 128;
  localparam int          PAY_AW     = 7;
  localparam logic [7:0]  XM_SOH   = 8'h01;
  localparam logic [7:0]  XM_EOT   = 8'h04;
  localparam logic [7:0]  XM_ACK   = 8'h06;
  localparam logic [7:0]  XM_NAK   = 8'h15;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [7:0]  XP_IDLE  = 8'h00;
  localparam logic [7:0]  XP_BLK   = 8'h01;
  localparam logic [7:0]  XP_NBLK  = 8'h02;
  localparam logic [7:0]  XP_DATA  = 8'h03;
  localparam logic [7:0]  XP_CRCH  = 8'h83;
  localparam logic [7:0]  XP_CRCL  = 8'h84;

  localparam int BANNER_LEN = 22;
  localparam int MENU_LEN   = 17;

  typedef enum logic [2:0] {
    ST_START, ST_CMD, ST_XWAIT, ST_XRECV, ST_COMMIT, ST_RUNOLD, ST_RUNNEW
  } sbiState_t;

  typedef enum logic [2:0] {
    MSG_BANNER, MSG_MENU, MSG_C, MSG_ACK, MSG_NAK
  } sbiMsg_t;
endpackage : sbi_pkg

/* File: sbi_image_mem.sv */
`timescale 1ns/1ps
module sbi_image_mem #(
  parameter int DW = 8,
  parameter int AW = 14
) (
  // Clock
  input  wire logic          clk,
  input  wire logic          clkEn,
  // Write side
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  // Read side, one cycle latency
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (clkEn) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end
endmodule : sbi_image_mem

/* File: sbi_boot_interp.sv */
// Notes on behaviour
// RULE1 - Boot session always starts at 9600 baud, 8 data bits, no parity, one stop.
// RULE2 - At start send banner: version, station number, duplex, then entry prompt.
// RULE3 - Wait about ten minutes for a command; timeout or cancel runs old firmware.
// RULE4 - Transfer command with one enters parameter mode and sends command menu.
// RULE5 - Transfer command with two starts the image transfer at once.
// RULE6 - Command letters must be upper case; lower case is refused.
// RULE7 - Baud select accepts eight-bit settings only; seven-bit settings refused.
// RULE8 - Station number accepts 0 to 99, rejects anything larger.
// RULE9 - Duplex select: one is full duplex, zero is half duplex.
// RULE10 - In parameter mode transfer command with zero ends boot, runs old firmware.
// RULE11 - Session settings live only during boot, never reach persistent storage.
// RULE12 - After start send 'C' repeatedly; host must begin within about 30 seconds.
// RULE13 - Each packet is CRC checked; bad or missing packets are refused and resent.
// RULE14 - Image is written to program memory only when complete, then started.
// RULE15 - If transfer stops, wait 20 seconds then start the old firmware.
// RULE16 - Transfer uses the CRC packet protocol with 128-byte payloads.
// RULE17 - Fast-start bypass skips the interpreter and runs the firmware directly.
// RULE18 - Timeouts come from prescaled counters; reset returns to banner, settings cleared.
`timescale 1ns/1ps
module sbi_boot_interp
  import sbi_pkg::*;
#(
  parameter int CYC_PER_MS_P  = sbi_pkg::CYC_PER_MS,
  parameter int CMD_WAIT_MS_P = sbi_pkg::CMD_WAIT_MS,
  parameter int CRC_REQ_MS_P  = sbi_pkg::CRC_REQ_MS,
  parameter int ABORT_MS_P    = sbi_pkg::ABORT_MS,
  parameter int IMG_AW        = 14
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  // Stored operating settings
  input  wire logic              fastStartBypass,
  input  wire logic [6:0]        storedStation,
  input  wire logic              storedDuplex,
  // Serial byte stream
  input  wire logic              rxValid,
  input  wire logic [7:0]        rxData,
  input  wire logic              txReady,
  output logic                   txValid,
  output logic      [7:0]        txData,
  // Session line settings
  output logic      [4:0]        sessionBaud,
  output logic      [6:0]        sessionStation,
  output logic                   sessionFullDuplex,
  // Program memory and hand-over
  output logic                   progWrEn,
  output logic      [IMG_AW-1:0] progAddr,
  output logic      [7:0]        progData,
  output logic                   bootActive,
  output logic                   runFirmware,
  output logic                   runNewImage
);
  import sbi_pkg::*;

  localparam int PRE_W = $clog2(CYC_PER_MS_P + 1);
  localparam int CW    = IMG_AW - PAY_AW;

  typedef struct packed {
    sbiState_t          st;
    logic               paramMode;
    logic [6:0]         station;
    logic [4:0]         baud;
    logic               fullDup;
    logic [PRE_W-1:0]   pre;
    logic [MS_W-1:0]    ms;
    logic [MS_W-1:0]    rep;
    logic [2:0]         pos;
    logic [6:0]         idv;
    logic [7:0]         l0;
    logic [7:0]         l1;
    logic [15:0]        val;
    logic               bad;
    logic               txV;
    logic [7:0]         txD;
    sbiMsg_t            msg;
    logic [4:0]         idx;
    logic [7:0]         xpos;
    logic [7:0]         expBlk;
    logic [7:0]         rBlk;
    logic               pkOk;
    logic               dup;
    logic [15:0]        crc;
    logic [7:0]         crcHi;
    logic [CW:0]        cnt;
    logic [IMG_AW:0]    cpAddr;
    logic               pend;
    logic               pWe;
    logic [IMG_AW-1:0]  pAddr;
    logic [7:0]         pData;
    logic               active;
    logic               runOld;
    logic               runNew;
  } sbiRegs_t;

  sbiRegs_t q;
  sbiRegs_t d;

  logic              memWe;
  logic [IMG_AW-1:0] memWa;
  logic [7:0]        memRd;
  logic              isDig;
  logic              isUp;
  logic [19:0]       vx;
  logic              sendGo;
  sbiMsg_t           sendMsg;
  logic [IMG_AW:0]   total;

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcStep

  function automatic logic [4:0] lastIdx(input sbiMsg_t m);
    unique case (m)
      MSG_BANNER: return 5'(BANNER_LEN - 1);
      MSG_MENU:   return 5'(MENU_LEN - 1);
      MSG_C, MSG_ACK, MSG_NAK: return 5'h00;
    endcase
  endfunction : lastIdx

  function automatic logic [7:0] msgByte(input sbiMsg_t m, input logic [4:0] i,
                                         input logic [6:0] stn, input logic fd);
    logic [BANNER_LEN-1:0][7:0] bn;
    logic [MENU_LEN-1:0][7:0]   mn;
    logic [7:0]                 t;
    logic [7:0]                 o;
    t  = CH_0 + {1'b0, stn / 7'd10};
    o  = CH_0 + {1'b0, stn % 7'd10};
    bn = {"BOOTV", BOOT_VER, " ID", t, o, " DM", CH_0 + {7'h00, fd}, CH_CR, t, o, "UP1", CH_CR};
    mn = {"BR ID DM UP0 UP2", CH_CR};
    unique case (m)
      MSG_BANNER: return bn[5'(BANNER_LEN - 1) - i];
      MSG_MENU:   return mn[5'(MENU_LEN - 1) - i];
      MSG_C:      return CH_C;
      MSG_ACK:    return XM_ACK;
      MSG_NAK:    return XM_NAK;
    endcase
  endfunction : msgByte

  sbi_image_mem #(.DW(8), .AW(IMG_AW)) imageBuf (
    .clk    (clk),
    .clkEn  (clkEn),
    .wrEn   (memWe),
    .wrAddr (memWa),
    .wrData (rxData),
    .rdAddr (q.cpAddr[IMG_AW-1:0]),
    .rdData (memRd)
  );

  assign isDig = (rxData >= CH_0) && (rxData <= CH_9);
  assign isUp  = (rxData >= CH_A) && (rxData <= CH_Z);
  assign vx    = {4'h0, q.val} * 20'h0_000A + {12'h000, rxData - CH_0};
  assign total = {q.cnt, PAY_AW'(0)};

  always_comb begin
    d       = q;
    memWe   = 1'b0;
    memWa   = {q.cnt[CW-1:0], PAY_AW'(q.xpos - XP_DATA)};
    sendGo  = 1'b0;
    sendMsg = MSG_C;
    d.pWe   = 1'b0;
    // Millisecond time base shared by every wait window [RULE18]
    if (q.pre == PRE_W'(CYC_PER_MS_P - 1)) begin
      d.pre = '0;
      if (q.ms != '1) d.ms = q.ms + 1'b1;
      if (q.rep != '1) d.rep = q.rep + 1'b1;
    end else begin
      d.pre = q.pre + 1'b1;
    end
    if (q.txV && txReady) begin
      if (q.idx == lastIdx(q.msg)) begin
        d.txV = 1'b0;
      end else begin
        d.idx = q.idx + 1'b1;
        d.txD = msgByte(q.msg, d.idx, q.station, q.fullDup);
      end
    end
    unique case (q.st)
      ST_START: begin
        d.baud      = BAUD_BOOT;     // [RULE1]
        d.station   = storedStation;
        d.fullDup   = storedDuplex;
        d.paramMode = 1'b0;
        d.ms        = '0;
        if (fastStartBypass) begin
          d.st = ST_RUNOLD;          // [RULE17]
        end else begin
          sendGo  = 1'b1;            // [RULE2]
          sendMsg = MSG_BANNER;
          d.st    = ST_CMD;
        end
      end
      ST_CMD: begin
        if (q.ms >= MS_W'(CMD_WAIT_MS_P)) begin
          d.st = ST_RUNOLD;          // [RULE3]
        end else if (rxValid && rxData == CH_CR) begin
          d.pos = '0;
          d.idv = '0;
          d.val = '0;
          d.bad = 1'b0;
          if (q.pos == PP_VALUE && !q.bad && q.idv == q.station) begin
            if ({q.l0, q.l1} == CMD_UP) begin
              d.ms = '0;
              if (q.val == UP_CANCEL) begin
                d.st = ST_RUNOLD;    // [RULE3] [RULE10]
              end else if (q.val == UP_PARAM) begin
                d.paramMode = 1'b1;  // [RULE4]
                sendGo      = 1'b1;
                sendMsg     = MSG_MENU;
              end else if (q.val == UP_START) begin
                d.st     = ST_XWAIT; // [RULE5]
                d.rep    = MS_W'(C_REPEAT_MS);
                d.expBlk = 8'h01;
                d.cnt    = '0;
              end
            end else if (q.paramMode) begin
              // Settings stay in these flops only, nothing is written back [RULE11]
              if ({q.l0, q.l1} == CMD_BAUD && q.val >= 16'(BAUD_MIN8) && q.val <= 16'(BAUD_MAX8)) begin
                d.baud = q.val[4:0]; // [RULE7]
                d.ms   = '0;
              end else if ({q.l0, q.l1} == CMD_STATION && q.val <= 16'(STATION_MAX)) begin
                d.station = q.val[6:0]; // [RULE8]
                d.ms      = '0;
              end else if ({q.l0, q.l1} == CMD_DUPLEX && q.val <= 16'(DUPLEX_MAX)) begin
                d.fullDup = q.val[0]; // [RULE9]
                d.ms      = '0;
              end
            end
          end
        end else if (rxValid) begin
          if (q.pos < PP_LETTER0) begin
            if (isDig) d.idv = 7'(q.idv * 7'd10) + 7'(rxData - CH_0);
            else d.bad = 1'b1;
          end else if (q.pos < PP_VALUE) begin
            if (!isUp) d.bad = 1'b1; // [RULE6]
            if (q.pos == PP_LETTER0) d.l0 = rxData;
            else d.l1 = rxData;
          end else begin
            if (isDig) d.val = (vx > 20'h0_FFFF) ? 16'hFFFF : vx[15:0];
            else d.bad = 1'b1;
          end
          if (q.pos != PP_VALUE) d.pos = q.pos + 1'b1;
        end
      end
      ST_XWAIT: begin
        if (q.ms >= MS_W'(CRC_REQ_MS_P)) begin
          d.st = ST_RUNOLD;          // [RULE12]
        end else if (rxValid && rxData == XM_SOH) begin
          d.st   = ST_XRECV;
          d.xpos = XP_BLK;
          d.rep  = '0;
        end else if (q.rep >= MS_W'(C_REPEAT_MS) && !q.txV) begin
          sendGo  = 1'b1;            // [RULE12]
          sendMsg = MSG_C;
          d.rep   = '0;
        end
      end
      ST_XRECV: begin
        if (rxValid) begin
          d.rep = '0;
          if (q.xpos == XP_IDLE) begin
            if (rxData == XM_SOH) begin
              d.xpos = XP_BLK;
            end else if (rxData == XM_EOT) begin
              sendGo   = 1'b1;
              sendMsg  = MSG_ACK;
              d.st     = ST_COMMIT;
              d.cpAddr = '0;
              d.pend   = 1'b0;
            end
          end else if (q.xpos == XP_BLK) begin
            d.rBlk = rxData;
            d.xpos = XP_NBLK;
          end else if (q.xpos == XP_NBLK) begin
            d.pkOk = q.rBlk == q.expBlk && rxData == ~q.rBlk && !q.cnt[CW];
            d.dup  = q.rBlk == q.expBlk - 8'h01 && rxData == ~q.rBlk;
            d.crc  = '0;
            d.xpos = XP_DATA;
          end else if (q.xpos < XP_CRCH) begin
            d.crc  = crcStep(q.crc, rxData); // [RULE16]
            memWe  = q.pkOk;
            d.xpos = q.xpos + 8'h01;
          end else if (q.xpos == XP_CRCH) begin
            d.crcHi = rxData;
            d.xpos  = XP_CRCL;
          end else begin
            sendGo = 1'b1;
            d.xpos = XP_IDLE;
            if ({q.crcHi, rxData} == q.crc && q.pkOk) begin
              sendMsg  = MSG_ACK;
              d.expBlk = q.expBlk + 8'h01;
              d.cnt    = q.cnt + 1'b1;
            end else if ({q.crcHi, rxData} == q.crc && q.dup) begin
              sendMsg = MSG_ACK;
            end else begin
              sendMsg = MSG_NAK;     // [RULE13]
            end
          end
        end else if (q.xpos != XP_IDLE && q.rep >= MS_W'(PKT_GAP_MS)) begin
          sendGo  = 1'b1;            // [RULE13]
          sendMsg = MSG_NAK;
          d.xpos  = XP_IDLE;
        end else if (q.xpos == XP_IDLE && q.rep >= MS_W'(ABORT_MS_P)) begin
          d.st = ST_RUNOLD;          // [RULE15]
        end
      end
      ST_COMMIT: begin
        // Program memory sees writes only once the image is complete [RULE14]
        d.pWe   = q.pend;
        d.pAddr = IMG_AW'(q.cpAddr - 1'b1);
        d.pData = memRd;
        if (total == '0) begin
          d.st = ST_RUNOLD;
        end else if (q.cpAddr == total) begin
          d.pend = 1'b0;
          d.st   = ST_RUNNEW;
        end else begin
          d.pend   = 1'b1;
          d.cpAddr = q.cpAddr + 1'b1;
        end
      end
      ST_RUNOLD: d.runOld = 1'b1;
      ST_RUNNEW: d.runNew = 1'b1;  // [RULE14]
    endcase
    // A reply that meets a busy transmitter is dropped; the host retries
    if (sendGo && !q.txV) begin
      d.txV = 1'b1;
      d.msg = sendMsg;
      d.idx = '0;
      d.txD = msgByte(sendMsg, 5'h00, d.station, d.fullDup);
    end
    d.active = d.st != ST_RUNOLD && d.st != ST_RUNNEW;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;                       // [RULE18]
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign txValid           = q.txV;
  assign txData            = q.txD;
  assign sessionBaud       = q.baud;
  assign sessionStation    = q.station;
  assign sessionFullDuplex = q.fullDup;
  assign progWrEn          = q.pWe;
  assign progAddr          = q.pAddr;
  assign progData          = q.pData;
  assign bootActive        = q.active;
  assign runFirmware       = q.runOld;
  assign runNewImage       = q.runNew;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  boot_baud_a: assert property (q.st == ST_CMD && !q.paramMode |-> sessionBaud == BAUD_BOOT) // [RULE1]
    else $error("boot baud not 9600");
  banner_start_a: assert property (q.st == ST_START && !fastStartBypass && clkEn
    |=> txValid && q.msg == MSG_BANNER && txData == "B") // [RULE2]
    else $error("banner not started");
  cmd_timeout_a: assert property (q.st == ST_CMD && q.ms >= MS_W'(CMD_WAIT_MS_P) && clkEn
    |=> q.st == ST_RUNOLD ##1 !clkEn || runFirmware) // [RULE3]
    else $error("command wait did not expire");
  upper_case_a: assert property (q.st == ST_CMD && rxValid && clkEn && q.pos == PP_LETTER0
    && !isUp && rxData != CH_CR |=> q.bad) // [RULE6]
    else $error("lower case letter accepted");
  // Baud is still zero in the first cycle after reset, before the start state loads it
  baud_range_a: assert property (q.st != ST_START |-> sessionBaud == BAUD_BOOT
    || (sessionBaud >= BAUD_MIN8 && sessionBaud <= BAUD_MAX8)) // [RULE7]
    else $error("seven bit baud accepted");
  station_range_a: assert property ($changed(sessionStation) && $past(q.st) == ST_CMD
    |-> sessionStation <= 7'(STATION_MAX)) // [RULE8]
    else $error("station out of range");
  crc_wait_a: assert property (q.st == ST_XWAIT && q.ms >= MS_W'(CRC_REQ_MS_P) && clkEn
    |=> q.st == ST_RUNOLD) // [RULE12]
    else $error("upload start wait did not expire");
  crc_nak_a: assert property (q.st == ST_XRECV && rxValid && clkEn && q.xpos == XP_CRCL
    && {q.crcHi, rxData} != q.crc && !q.txV |=> txValid && txData == XM_NAK) // [RULE13]
    else $error("bad packet not refused");
  commit_only_a: assert property (progWrEn |-> $past(q.st) == ST_COMMIT) // [RULE14]
    else $error("program write outside commit");
  abort_old_a: assert property (q.st == ST_XRECV && q.xpos == XP_IDLE && !rxValid
    && q.rep >= MS_W'(ABORT_MS_P) && clkEn |=> q.st == ST_RUNOLD) // [RULE15]
    else $error("stalled transfer not aborted");
  bypass_skip_a: assert property (q.st == ST_START && fastStartBypass && clkEn
    |=> q.st == ST_RUNOLD && !txValid) // [RULE17]
    else $error("bypass did not skip boot");

  param_mode_c: cover property (q.st == ST_CMD && q.paramMode && txValid && q.msg == MSG_MENU);
  upload_start_c: cover property (q.st == ST_XWAIT ##1 q.st == ST_XRECV);
  new_image_c: cover property (progWrEn ##[1:20] runNewImage);
  old_run_c: cover property (q.st == ST_XRECV ##2 runFirmware);
endmodule : sbi_boot_interp

/* File: sbi_host_model.sv */
`timescale 1ns/1ps
module sbi_host_model (
  // Clock and pacing
  input  wire logic       clk,
  input  wire logic       slowMode,
  // Device transmit side
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // Device receive side
  output logic            rxValid,
  output logic      [7:0] rxData
);
  logic [7:0] gotQ [$];
  logic       phase;

  initial begin
    rxValid = 1'h0;
    rxData  = 8'hFF;
    txReady = 1'h1;
    phase   = 1'h0;
  end

  // Slow mode stalls the device transmitter every other cycle
  always @(negedge clk) begin
    phase   <= ~phase;
    txReady <= ~slowMode | phase;
  end

  always @(posedge clk) begin
    if (txValid && txReady) begin
      gotQ.push_back(txData);
    end
  end

  // Idle line shows the inverse of the last byte so stale data never matches
  task automatic sendByte(input logic [7:0] b);
    @(negedge clk);
    rxValid = 1'h1;
    rxData  = b;
    @(negedge clk);
    rxValid = 1'h0;
    rxData  = ~b;
  endtask : sendByte
endmodule : sbi_host_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  import sbi_pkg::*;
  logic       clk, sys_rst, clkEn, fastStartBypass, storedDuplex, slowMode;
  logic [6:0] storedStation, sessionStation;
  logic       rxValid, txReady, txValid, progWrEn, bootActive;
  logic       runFirmware, runNewImage, sessionFullDuplex;
  logic [7:0] rxData, txData, progData, progAddr;
  logic [4:0] sessionBaud;
  logic [7:0] img [256];
  int         failures, num_checks, wrCount, expBaud;
  string      stn;

  always #2.5 clk = ~clk;

  sbi_boot_interp #(.CYC_PER_MS_P(4), .CMD_WAIT_MS_P(20), .CRC_REQ_MS_P(10), .ABORT_MS_P(10), .IMG_AW(8))
  u_sbi_boot_interp (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .fastStartBypass(fastStartBypass),
    .storedStation(storedStation), .storedDuplex(storedDuplex), .rxValid(rxValid), .rxData(rxData),
    .txReady(txReady), .txValid(txValid), .txData(txData), .sessionBaud(sessionBaud),
    .sessionStation(sessionStation), .sessionFullDuplex(sessionFullDuplex), .progWrEn(progWrEn),
    .progAddr(progAddr), .progData(progData), .bootActive(bootActive), .runFirmware(runFirmware),
    .runNewImage(runNewImage));

  sbi_host_model u_sbi_host_model (.clk(clk), .slowMode(slowMode), .txValid(txValid), .txData(txData),
    .txReady(txReady), .rxValid(rxValid), .rxData(rxData));

  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic checkVal(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h got %h", nm, exp, got);
    end
  endtask : checkVal

  // Image writes must land in address order with the data as received
  always @(negedge clk) begin
    if (progWrEn === 1'h1) begin
      checkVal("progAddr", 16'(wrCount), 16'(progAddr));
      checkVal("progData", 16'(img[wrCount[7:0]]), 16'(progData));
      wrCount++;
    end
  end

  task automatic doReset(input logic bypass);
    @(negedge clk);
    sys_rst         = 1'h1;
    fastStartBypass = bypass;
    repeat (8) @(negedge clk);
    u_sbi_host_model.gotQ.delete();
    wrCount = 0;
    stn     = "42";
    checkVal("rstActive", 16'h0000, 16'(bootActive));
    checkVal("rstBaud", 16'h0000, 16'(sessionBaud));
    sys_rst = 1'h0;
    repeat (2) @(negedge clk);
  endtask : doReset

  task automatic waitBytes(input int n);
    int k;
    for (k = 0; k < 3000 && u_sbi_host_model.gotQ.size() < n; k++) @(negedge clk);
    if (k == 3000) begin
      checkVal("txBytes", 16'(n), 16'(u_sbi_host_model.gotQ.size()));
      print_verdict();
    end
  endtask : waitBytes

  task automatic waitRun(input logic wantNew);
    int k;
    for (k = 0; k < 3000 && (wantNew ? runNewImage : runFirmware) !== 1'h1; k++) @(negedge clk);
    checkVal("runNew", 16'(wantNew), 16'(runNewImage));
    checkVal("runOld", 16'(!wantNew), 16'(runFirmware));
    if (k == 3000) print_verdict();
  endtask : waitRun

  task automatic expectStr(input string nm, input string s, input int from);
    waitBytes(from + s.len());
    for (int i = 0; i < s.len(); i++) checkVal(nm, 16'(s[i]), 16'(u_sbi_host_model.gotQ[from+i]));
  endtask : expectStr

  task automatic sendStr(input string s);
    for (int i = 0; i < s.len(); i++) u_sbi_host_model.sendByte(s[i]);
    repeat (4) @(negedge clk);
  endtask : sendStr

  task automatic cmdV(input string c, input int v);
    sendStr($sformatf("%s%s%0d\r", stn, c, v));
  endtask : cmdV

  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int b = 0; b < 8; b++) r = r[15] ? {r[14:0], 1'h0} ^ CRC_POLY : {r[14:0], 1'h0};
    return r;
  endfunction : crcStep

  // Packet of 128 payload bytes; bad flips the last check bit
  task automatic sendPacket(input int blk, input int base, input logic bad);
    logic [15:0] crc;
    crc = 16'h0000;
    u_sbi_host_model.sendByte(XM_SOH);
    u_sbi_host_model.sendByte(8'(blk));
    u_sbi_host_model.sendByte(~8'(blk));
    for (int i = 0; i < XM_PAYLOAD; i++) begin
      crc = crcStep(crc, img[base+i]);
      u_sbi_host_model.sendByte(img[base+i]);
    end
    u_sbi_host_model.sendByte(crc[15:8]);
    u_sbi_host_model.sendByte(crc[7:0] ^ {7'h00, bad});
  endtask : sendPacket

  initial begin
    clk = 1'h0; sys_rst = 1'h1; clkEn = 1'h1; fastStartBypass = 1'h0; slowMode = 1'h0;
    storedStation = 7'h2A; storedDuplex = 1'h1; failures = 0; num_checks = 0; wrCount = 0;
    for (int i = 0; i < 256; i++) img[i] = 8'(i) ^ 8'h5A;
    doReset(1'h1);
    waitRun(1'h0);
    checkVal("bypassTx", 16'h0000, 16'(u_sbi_host_model.gotQ.size()));
    doReset(1'h0);
    waitBytes(22);
    cmdV("UP", 1);
    expectStr("menu", "BR ID DM UP0 UP2\r", 22);
    sendStr("42br3\r");
    checkVal("baudLower", 16'(BAUD_BOOT), 16'(sessionBaud));
    expBaud = 5;
    for (int i = 0; i < 10; i++) begin
      cmdV("BR", (i < 8) ? i + 10 : i - 8);
      checkVal("baudKeep", 16'(expBaud), 16'(sessionBaud));
      if (i < 8) begin
        expBaud = i + 2;
        cmdV("BR", expBaud);
        checkVal("baudSet", 16'(expBaud), 16'(sessionBaud));
      end
    end
    cmdV("ID", 100);
    checkVal("stnKeep", 16'h002A, 16'(sessionStation));
    cmdV("DM", 0);
    checkVal("duplex0", 16'h0000, 16'(sessionFullDuplex));
    cmdV("DM", 1);
    checkVal("duplex1", 16'h0001, 16'(sessionFullDuplex));
    cmdV("ID", 99);
    checkVal("stnSet", 16'h0063, 16'(sessionStation));
    cmdV("DM", 0);
    checkVal("wrongStn", 16'h0001, 16'(sessionFullDuplex));
    stn = "99";
    cmdV("UP", 0);
    waitRun(1'h0);
    slowMode = 1'h1;
    doReset(1'h0);
    checkVal("baudBoot", 16'(BAUD_BOOT), 16'(sessionBaud));
    checkVal("stnBack", 16'h002A, 16'(sessionStation));
    checkVal("active", 16'h0001, 16'(bootActive));
    expectStr("banner", "BOOTV3 ID42 DM1\r42UP1\r", 0);
    waitRun(1'h0);
    slowMode = 1'h0;
    doReset(1'h0);
    waitBytes(22);
    clkEn = 1'h0;
    repeat (100) @(negedge clk);
    checkVal("frozen", 16'h0001, 16'(bootActive));
    clkEn = 1'h1;
    cmdV("UP", 2);
    expectStr("crcReq", "C", 22);
    waitRun(1'h0);
    doReset(1'h0);
    waitBytes(22);
    cmdV("UP", 2);
    expectStr("crcReq", "C", 22);
    sendPacket(1, 0, 1'h1);
    expectStr("nak", string'(XM_NAK), 23);
    sendPacket(1, 0, 1'h0);
    expectStr("ack1", string'(XM_ACK), 24);
    sendPacket(2, 128, 1'h0);
    expectStr("ack2", string'(XM_ACK), 25);
    checkVal("earlyWrites", 16'h0000, 16'(wrCount));
    u_sbi_host_model.sendByte(XM_EOT);
    expectStr("ackEnd", string'(XM_ACK), 26);
    waitRun(1'h1);
    checkVal("writes", 16'h0100, 16'(wrCount));
    doReset(1'h0);
    waitBytes(22);
    cmdV("UP", 2);
    waitBytes(23);
    sendPacket(1, 0, 1'h0);
    waitBytes(24);
    waitRun(1'h0);
    checkVal("abortWrites", 16'h0000, 16'(wrCount));
    print_verdict();
  end
endmodule : testbench
